// [anar_regs.sv]
// anar_regs: apb register bank for identifier and advertisement registers
// assumes apb requests synchronous to CORE_CLK_I; fault and strap are synchronous levels
//
// Local design decision: register access over APB.
`timescale 1ns/1ns
`default_nettype none

// Overview of operation
// [R1] identifier low register returns a fixed six-bit model code
// [R2] identifier low register returns a fixed four-bit revision code
// [R3] link code word is built from the current advertisement contents whether or not negotiation is enabled
// [R4] next-page bit is read/write, reset zero, and advertised as written
// [R5] reserved advertisement bits 14 and 12:10 always read zero
// [R6] software writes default values into reserved bits on every write
// [R7] writes to bit 14 are ignored unless the override bit is set
// [R8] all override-write bits are protected unless the override bit is set
// [R9] remote-fault bit follows the local link fault detector
// [R10] each ability bit advertises or denies its technology
// [R11] the 100base-t4 ability bit always reads zero
// [R12] with negotiation enabled all four ability bits default to one
// [R13] negotiation disabled sets idle mode; rate and duplex outputs follow their control bits
// [R14] selector field is override-write with default 00001
// [R15] status capability bits stay fixed regardless of advertised abilities
// [R16] software rewrites abilities and then requests a negotiation restart
// [R17] ability defaults come from negotiation enable alone; the strap pin does not change them
// [R18] identifier bits readable always, writable only with override set
// [R19] registers are 16 bits wide, each at a byte address four times its register number
module anar_regs
  import anar_pkg::*;
#(
  parameter logic [5:0] MODEL_CODE = 6'h2A,  // arbitrary value
  parameter logic [3:0] REV_CODE = 4'h7,     // arbitrary value
  parameter logic [5:0] OUI_TAIL = 6'h15     // arbitrary value
) (
  // clock and reset
  input wire logic CORE_CLK_I,
  input wire logic RST_N_I,
  // apb slave
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [7:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  // device side
  input wire logic LINK_FAULT_I,
  input wire logic STRAP_CONFIG_SELECT_PIN_I,
  output logic [15:0] LINK_CODE_WORD_O,
  output logic AN_ENABLE_O,
  output logic AN_RESTART_O,
  output logic IDLE_MODE_O,
  output logic RATE_100_O,
  output logic FULL_DUPLEX_O
);

  logic [15:0] ctl_ff, nxt_ctl;
  logic [15:0] vnd_ff, nxt_vnd;
  logic [15:0] adv_ff, nxt_adv;
  logic [15:0] id_ff, nxt_id;
  logic init_ff, nxt_init;
  logic restart_ff, nxt_restart;
  logic [31:0] rdata_ff, nxt_rdata;
  logic err_ff, nxt_err;
  logic access, wr, ovr, mapped;
  logic ack_ff, nxt_ack;
  logic [15:0] wdat, adv_rd;

  // merge write data under a mask of writable bits
  function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] nw,
                                        input logic [15:0] mask);
    merge = (old & ~mask) | (nw & mask);
  endfunction

  assign access = PSEL_I && PENABLE_I;
  // a write lands only at the edge where the ready answer is sampled high
  assign wr = access && PWRITE_I && ack_ff;
  assign wdat = PWDATA_I[REG_W-1:0];
  assign ovr = vnd_ff[VND_OVR_BIT];
  assign mapped = (PADDR_I == ADDR_CONTROL) || (PADDR_I == ADDR_STATUS) ||
                  (PADDR_I == ADDR_ID_LOW) || (PADDR_I == ADDR_ADVERT) ||
                  (PADDR_I == ADDR_VENDOR_CTRL);

  // readback view of advertisement
  always_comb begin
    adv_rd = adv_ff & ~ADV_RSV_MASK; // R5
    adv_rd[ADV_T4_BIT] = 1'b0; // R11
    adv_rd[ADV_RF_BIT] = LINK_FAULT_I; // R9
  end

  always_comb begin
    nxt_ctl = ctl_ff;
    nxt_vnd = vnd_ff;
    nxt_adv = adv_ff;
    nxt_id = id_ff;
    nxt_init = 1'b0;
    nxt_restart = 1'b0;
    nxt_rdata = rdata_ff;
    nxt_err = 1'b0;
    // defaults of ability bits caught one cycle after reset release
    if (init_ff) begin
      if (ctl_ff[CTL_AN_EN_BIT] && !STRAP_CONFIG_SELECT_PIN_I) begin
        nxt_adv[ADV_TAF_HI:ADV_TAF_LO] = TAF_ALL; // R12 R17
      end else begin
        nxt_adv[ADV_TAF_HI:ADV_TAF_LO] = TAF_ALL & {4{ctl_ff[CTL_AN_EN_BIT]}}; // R17
      end
    end
    nxt_adv[ADV_RF_BIT] = LINK_FAULT_I; // R9
    if (access) begin
      nxt_err = !mapped;
      nxt_rdata = '0;
      unique case (PADDR_I)
        ADDR_CONTROL: nxt_rdata[REG_W-1:0] = ctl_ff;
        ADDR_STATUS: nxt_rdata[REG_W-1:0] = STATUS_CAPS; // R15
        ADDR_ID_LOW: nxt_rdata[REG_W-1:0] = id_ff; // R1 R2 R18
        ADDR_ADVERT: nxt_rdata[REG_W-1:0] = adv_rd;
        ADDR_VENDOR_CTRL: nxt_rdata[REG_W-1:0] = vnd_ff;
        default: nxt_rdata = '0;
      endcase
    end
    if (wr) begin
      unique case (PADDR_I)
        ADDR_CONTROL: begin
          nxt_ctl = wdat;
          nxt_ctl[CTL_RESTART_BIT] = 1'b0;
          nxt_restart = wdat[CTL_RESTART_BIT]; // R16
        end
        ADDR_ID_LOW: begin
          if (ovr) begin
            nxt_id = wdat; // R18
          end
        end
        ADDR_ADVERT: begin
          nxt_adv = merge(adv_ff, wdat, ADV_RW_MASK); // R4 R10
          if (ovr) begin
            nxt_adv = merge(nxt_adv, wdat, ADV_OVR_MASK); // R7 R8 R14
          end
          nxt_adv[ADV_RF_BIT] = LINK_FAULT_I; // R9
        end
        ADDR_VENDOR_CTRL: nxt_vnd = wdat;
        default: nxt_vnd = vnd_ff;
      endcase
    end
  end

  always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      ctl_ff <= CTL_RESET;
      vnd_ff <= '0;
      adv_ff <= {11'h000, ADV_SEL_RESET}; // R14
      id_ff <= '0;
      init_ff <= 1'b1;
      restart_ff <= 1'b0;
      rdata_ff <= '0;
      err_ff <= 1'b0;
    end else begin
      ctl_ff <= nxt_ctl;
      vnd_ff <= nxt_vnd;
      adv_ff <= nxt_adv;
      id_ff <= init_ff ? {OUI_TAIL, MODEL_CODE, REV_CODE} : nxt_id; // R1 R2
      init_ff <= nxt_init;
      restart_ff <= nxt_restart;
      rdata_ff <= nxt_rdata;
      err_ff <= nxt_err;
    end
  end

  // registered read answer arrives one cycle into the access phase
  always_comb begin
    nxt_ack = access && !ack_ff;
  end
  always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= nxt_ack;
    end
  end

  assign PREADY_O = ack_ff;
  assign PRDATA_O = rdata_ff;
  assign PSLVERR_O = ack_ff && err_ff;

  // link code word and mode outputs
  assign LINK_CODE_WORD_O = adv_ff & ~ADV_RSV_MASK & ~(16'h0001 << ADV_T4_BIT); // R3 R10 R11
  assign AN_ENABLE_O = ctl_ff[CTL_AN_EN_BIT];
  assign AN_RESTART_O = restart_ff;
  assign IDLE_MODE_O = !ctl_ff[CTL_AN_EN_BIT]; // R13
  assign RATE_100_O = ctl_ff[CTL_RATE_BIT]; // R13
  assign FULL_DUPLEX_O = ctl_ff[CTL_DUPLEX_BIT]; // R13

endmodule // anar_regs
`default_nettype wire

// [anar_pkg.sv]
// anar_pkg: register map, field layout and reset values of the advertisement block
// assumes a 32-bit apb bus with word-aligned registers holding 16-bit data
package anar_pkg;
  localparam logic [7:0] ADDR_CONTROL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_ID_LOW = 8'h0C;
  localparam logic [7:0] ADDR_ADVERT = 8'h10;
  localparam logic [7:0] ADDR_VENDOR_CTRL = 8'h40;
  localparam int REG_W = 16;
  // control register fields
  localparam int CTL_RESTART_BIT = 9;
  localparam int CTL_DUPLEX_BIT = 8;
  localparam int CTL_AN_EN_BIT = 12;
  localparam int CTL_RATE_BIT = 13;
  localparam logic [15:0] CTL_RESET = 16'h3100;
  // vendor control: override bit
  localparam int VND_OVR_BIT = 15;
  // advertisement fields
  localparam int ADV_NP_BIT = 15;
  localparam int ADV_ACK_BIT = 14;
  localparam int ADV_RF_BIT = 13;
  localparam int ADV_T4_BIT = 9;
  localparam int ADV_TAF_HI = 8;
  localparam int ADV_TAF_LO = 5;
  localparam logic [15:0] ADV_RSV_MASK = 16'h5C00;
  localparam logic [15:0] ADV_OVR_MASK = 16'h5E1F;
  localparam logic [15:0] ADV_RW_MASK = 16'h81E0;
  localparam logic [4:0] ADV_SEL_RESET = 5'h01;
  localparam logic [3:0] TAF_ALL = 4'hF;
  // status register: full capability bits, fixed
  localparam logic [15:0] STATUS_CAPS = 16'h7809;
  localparam int ID_MODEL_LO = 4;
  localparam int ID_REV_LO = 0;
endpackage

// [anar_asserts.sv]
// anar_asserts: port checks of the advertisement register bank
// assumes binding to anar_regs
`timescale 1ns/1ns
`default_nettype none
module anar_asserts
  import anar_pkg::*;
#(parameter logic [5:0] MODEL_CODE = 6'h2A, parameter logic [3:0] REV_CODE = 4'h7) (
  // watched ports
  input wire logic CORE_CLK_I,
  input wire logic RST_N_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [7:0] PADDR_I,
  input wire logic [31:0] PRDATA_O,
  input wire logic PREADY_O,
  input wire logic LINK_FAULT_I,
  input wire logic [15:0] LINK_CODE_WORD_O,
  input wire logic AN_ENABLE_O,
  input wire logic IDLE_MODE_O
);
  default clocking @(posedge CORE_CLK_I); endclocking
  default disable iff (!RST_N_I);
  wire rd_ack = PREADY_O & ~PWRITE_I;
  a_rsv_read_zero: assert property (rd_ack && PADDR_I == ADDR_ADVERT
    |-> (PRDATA_O[15:0] & 16'h5E00) == 16'h0000) else $error("reserved bits set");
  a_id_model: assert property (rd_ack && PADDR_I == ADDR_ID_LOW
    |-> PRDATA_O[9:4] == MODEL_CODE) else $error("model code");
  a_id_rev: assert property (rd_ack && PADDR_I == ADDR_ID_LOW
    |-> PRDATA_O[3:0] == REV_CODE) else $error("revision code");
  a_ready_wait: assert property (PSEL_I && PENABLE_I && !$past(PENABLE_I)
    |-> !PREADY_O ##1 PREADY_O) else $error("ready timing");
  a_ready_pulse: assert property (PREADY_O |=> !PREADY_O) else $error("ready width");
  a_lcw_rsv_zero: assert property ((LINK_CODE_WORD_O & 16'h5E00) == 16'h0000)
    else $error("code word reserved");
  a_fault_track: assert property ($stable(LINK_FAULT_I)
    |=> LINK_CODE_WORD_O[ADV_RF_BIT] == $past(LINK_FAULT_I)) else $error("fault bit");
  a_idle_mode: assert property (IDLE_MODE_O == !AN_ENABLE_O) else $error("idle mode");
endmodule // anar_asserts
bind anar_regs anar_asserts #(.MODEL_CODE(MODEL_CODE), .REV_CODE(REV_CODE)) i_anar_asserts (
  .CORE_CLK_I, .RST_N_I, .PSEL_I, .PENABLE_I, .PWRITE_I, .PADDR_I, .PRDATA_O, .PREADY_O,
  .LINK_FAULT_I, .LINK_CODE_WORD_O, .AN_ENABLE_O, .IDLE_MODE_O);
`default_nettype wire

// [anar_sme.sv]
// anar_sme: management station model, an apb master
// assumes the bench calls xfer from one process
`timescale 1ns/1ns
`default_nettype none
module anar_sme (
  // bus side
  input wire logic clk_i,
  input wire logic pready_i,
  input wire logic pslverr_i,
  input wire logic [31:0] prdata_i,
  output logic psel_o = 1'b0,
  output logic penable_o = 1'b0,
  output logic pwrite_o = 1'b0,
  output logic [7:0] paddr_o = 8'h00,
  output logic [31:0] pwdata_o = 32'h0
);
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
    @(posedge clk_i);
    psel_o <= 1'b1;
    pwrite_o <= w;
    paddr_o <= a;
    pwdata_o <= d;
    @(posedge clk_i);
    penable_o <= 1'b1;
    do @(posedge clk_i); while (pready_i !== 1'b1);
    r = prdata_i;
    e = pslverr_i;
    psel_o <= 1'b0;
    penable_o <= 1'b0;
    // released lines must not keep the old value
    paddr_o <= ~a;
    pwdata_o <= ~d;
  endtask
endmodule // anar_sme
`default_nettype wire

// [test_anar_regs.sv]
// test_anar_regs: table bench of the advertisement register bank
// assumes anar_sme as bus master
`timescale 1ns/1ns
`default_nettype none
module test_anar_regs
  import anar_pkg::*;
;
  typedef struct packed {logic w; logic [7:0] a; logic [15:0] d; logic [15:0] x; logic e;} anar_row_s;
  logic core_clk = 0, rst_n = 0, link_fault = 0, strap = 0, er;
  logic psel, penable, pwrite, pready, pslverr, an_en, restart, idle, rate, fdx;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] lcw;
  int n_mismatch = 0, n_tests = 0, n_restart = 0;
  anar_row_s rows [14] = '{
    '{0, ADDR_ADVERT, 16'h0, 16'h01E1, 0},
    '{1, ADDR_ADVERT, 16'hDE00, 16'h0, 0},
    '{0, ADDR_ADVERT, 16'h0, 16'h8001, 0},
    '{1, ADDR_VENDOR_CTRL, 16'h8000, 16'h0, 0},
    '{1, ADDR_ADVERT, 16'h5E1E, 16'h0, 0},
    '{0, ADDR_ADVERT, 16'h0, 16'h001E, 0},
    '{1, ADDR_VENDOR_CTRL, 16'h0, 16'h0, 0},
    '{0, ADDR_ID_LOW, 16'h0, 16'h56A7, 0},
    '{1, ADDR_ID_LOW, 16'h0000, 16'h0, 0},
    '{0, ADDR_ID_LOW, 16'h0, 16'h56A7, 0},
    '{1, ADDR_ADVERT, 16'h01E1, 16'h0, 0},
    '{0, ADDR_ADVERT, 16'h0, 16'h01FE, 0},
    '{0, ADDR_STATUS, 16'h0, 16'h7809, 0},
    '{0, 8'h20, 16'h0, 16'h0, 1}};
  anar_regs i_anar_regs (.CORE_CLK_I(core_clk), .RST_N_I(rst_n), .PSEL_I(psel),
    .PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata),
    .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr), .LINK_FAULT_I(link_fault),
    .STRAP_CONFIG_SELECT_PIN_I(strap), .LINK_CODE_WORD_O(lcw), .AN_ENABLE_O(an_en),
    .AN_RESTART_O(restart), .IDLE_MODE_O(idle), .RATE_100_O(rate), .FULL_DUPLEX_O(fdx));
  anar_sme i_anar_sme (.clk_i(core_clk), .pready_i(pready), .pslverr_i(pslverr),
    .prdata_i(prdata), .psel_o(psel), .penable_o(penable), .pwrite_o(pwrite),
    .paddr_o(paddr), .pwdata_o(pwdata));
  initial forever #2 core_clk = ~core_clk;
  always @(posedge core_clk) if (restart === 1'b1) n_restart++;
  task check(input string n, input logic [31:0] s, input logic [31:0] x);
    n_tests++;
    if (s !== x) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", n, x, s);
    end
  endtask
  task rw(input logic w, input logic [7:0] a, input logic [15:0] d);
    i_anar_sme.xfer(w, a, {16'h0, d}, rd, er);
  endtask
  task complete_run;
    $display("counts: %0d compared, %0d mismatched", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (3000) @(posedge core_clk);
    n_mismatch++;
    complete_run;
  end
  initial begin
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    foreach (rows[i]) begin
      rw(rows[i].w, rows[i].a, rows[i].d);
      check("slverr", {31'h0, er}, {31'h0, rows[i].e});
      if (!rows[i].w) check("read", rd, {16'h0, rows[i].x});
    end
    check("code word", {16'h0, lcw}, 32'h01FE);
    $display("table done");
    link_fault <= 1'b1;
    repeat (3) @(posedge core_clk);
    rw(0, ADDR_ADVERT, 16'h0);
    check("fault", {lcw, rd[15:0]}, 32'h21FE21FE);
    link_fault <= 1'b0;
    rw(1, ADDR_CONTROL, 16'h0000);
    @(posedge core_clk);
    check("mode off", {28'h0, an_en, idle, rate, fdx}, 32'h4);
    rw(1, ADDR_CONTROL, 16'h3300);
    repeat (2) @(posedge core_clk);
    check("mode on", {28'h0, an_en, idle, rate, fdx}, 32'hB);
    check("restart", n_restart, 32'h1);
    $display("mode done");
    strap <= 1'b1;
    rst_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    rw(0, ADDR_ADVERT, 16'h0);
    check("strap", rd, 32'h01E1);
    $display("reset done");
    complete_run;
  end
endmodule // test_anar_regs
`default_nettype wire
